/* File: core/pta_defs.svh */
// register map, field positions, reset values and table constants
`ifndef PTA_DEFS_SVH
`define PTA_DEFS_SVH

// -----------------------------------------------------------------
// register indices (byte address = index * 4)
// -----------------------------------------------------------------
`define PTA_IDX_SCALE        8'h07
`define PTA_IDX_ACCESS       8'h08
`define PTA_IDX_DATA         8'h09
`define PTA_IDX_RECOMMEND    8'h0F
`define PTA_ADDR_W           8

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define PTA_TRIG_BIT         7
`define PTA_DIR_BIT          6
`define PTA_UI_HI            5
`define PTA_UI_LO            4
`define PTA_SAMP_HI          3
`define PTA_SAMP_LO          0
`define PTA_SCALE_W          6
`define PTA_AMP_W            7
`define PTA_RAM_AW           6
`define PTA_RAM_DEPTH        64
`define PTA_PROD_W           13

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define PTA_SCALE_RST        6'h21
`define PTA_ACCESS_RST       8'h00
`define PTA_DATA_RST         7'h00

// -----------------------------------------------------------------
// recommended scale values and step sizes (hundredths of a percent)
// -----------------------------------------------------------------
`define PTA_REC_T1_SH        6'h36
`define PTA_REC_LB_7P5       6'h11
`define PTA_REC_LB_15        6'h08
`define PTA_REC_LB_22P5      6'h04
`define PTA_REC_E1           6'h21
`define PTA_STEP_T1_SH       12'h0C8
`define PTA_STEP_LB_7P5      12'h271
`define PTA_STEP_LB_15       12'h4E2
`define PTA_STEP_LB_22P5     12'h9C4
`define PTA_STEP_E1          12'h12C

// -----------------------------------------------------------------
// bus responses
// -----------------------------------------------------------------
`define PTA_RESP_OKAY        2'h0
`define PTA_RESP_SLVERR      2'h2

`endif

/* File: core/pta_pkg.sv */
// types for the pulse template access block
package pta_pkg;

  // -----------------------------------------------------------------
  // access sequencer states, gray along idle -> exec -> finish
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTA_IDLE   = 2'h0,
    PTA_EXEC   = 2'h1,
    PTA_FINISH = 2'h3
  } pta_state_t;

  // line type groups selecting a recommended scale
  typedef enum logic [2:0] {
    PTA_LT_E1     = 3'h0,
    PTA_LT_T1_SH  = 3'h1,
    PTA_LT_LB_7P5 = 3'h2,
    PTA_LT_LB_15  = 3'h3,
    PTA_LT_LB_225 = 3'h4
  } pta_line_t;

endpackage : pta_pkg

/* File: core/pta_top.sv */
// pulse template ram access and amplitude scale registers, axi4-lite slave
//
// Overview of operation
// R1: 6-bit amplitude_scale register multiplies every transmitted template sample amplitude.
// R2: amplitude_scale resets to 100001; upper two register bits reserved, read zero.
// R3: short-haul T1/J1 and 0 dB build-out: recommend 110110, 2 percent per step.
// R4: -7.5 dB build-out: recommend 010001, 6.25 percent per step.
// R5: -15.0 dB build-out: recommend 001000, 12.5 percent per step.
// R6: -22.5 dB build-out: recommend 000100, 25 percent per step.
// R7: E1 75 or 120 ohm: recommend 100001, 3 percent per step.
// R8: writing one to control bit 7 starts one template ram access.
// R9: control bit 6 picks direction: zero writes ram, one reads ram.
// R10: control bits 5:4 pick one of four unit intervals, zero leftmost.
// R11: control bits 3:0 pick one of sixteen samples, zero leftmost.
// R12: indirect write stores data register sample_amplitude at the addressed location.
// R13: indirect read returns stored amplitude into sample_amplitude; bit 7 reads zero.
// R14: software sets fields before or with trigger and waits for completion.
`timescale 1ns/1ps
`default_nettype none
`include "pta_defs.svh"

module pta_top (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     s_axi_awvalid,
  output var  logic                     s_axi_awready,
  input  wire logic [31:0]              s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_wvalid,
  output var  logic                     s_axi_wready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  output var  logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  output var  logic [1:0]               s_axi_bresp,
  input  wire logic                     s_axi_arvalid,
  output var  logic                     s_axi_arready,
  input  wire logic [31:0]              s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  output var  logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output var  logic [31:0]              s_axi_rdata,
  output var  logic [1:0]               s_axi_rresp,
  input  wire logic [2:0]               line_type,
  input  wire logic [5:0]               tx_sample_addr,
  output var  logic [`PTA_PROD_W-1:0]   tx_scaled_amp,
  output var  logic                     access_busy
);

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [`PTA_AMP_W-1:0]   ram_q [0:`PTA_RAM_DEPTH-1];
  logic [`PTA_SCALE_W-1:0] scale_q;
  logic                    trig_q;
  logic                    dir_q;
  logic [1:0]              ui_q;
  logic [3:0]              samp_q;
  logic [`PTA_AMP_W-1:0]   data_q;
  pta_pkg::pta_state_t     state_q;
  pta_pkg::pta_state_t     state_d;

  // -----------------------------------------------------------------
  // bus side state
  // -----------------------------------------------------------------
  logic                    aw_got_q;
  logic                    w_got_q;
  logic [`PTA_ADDR_W-1:0]  aw_idx_q;
  logic [7:0]              w_byte_q;
  logic                    w_lane0_q;
  logic                    aw_hs;
  logic                    w_hs;
  logic                    wr_fire;
  logic [`PTA_ADDR_W-1:0]  wr_idx;
  logic [7:0]              wr_byte;
  logic                    wr_en;
  logic                    wr_mapped;
  logic                    wr_scale;
  logic                    wr_access;
  logic                    wr_data;
  logic [`PTA_ADDR_W-1:0]  rd_idx;
  logic                    rd_mapped;
  logic [31:0]             rd_word;
  logic [`PTA_SCALE_W-1:0] rec_scale;
  logic [11:0]             rec_step;
  logic [`PTA_RAM_AW-1:0]  ram_addr;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs  = s_axi_wvalid & s_axi_wready;

  // address and data may arrive in the same cycle or apart
  assign wr_fire = (aw_got_q | aw_hs) & (w_got_q | w_hs) & ~s_axi_bvalid;
  assign wr_idx  = aw_got_q ? aw_idx_q : s_axi_awaddr[`PTA_ADDR_W+1:2];
  assign wr_byte = w_got_q ? w_byte_q : s_axi_wdata[7:0];
  assign wr_en   = wr_fire & (w_got_q ? w_lane0_q : s_axi_wstrb[0]);

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  always_comb begin
    wr_mapped = 1'b0;
    wr_scale  = 1'b0;
    wr_access = 1'b0;
    wr_data   = 1'b0;
    case (wr_idx)
      `PTA_IDX_SCALE: begin
        wr_mapped = 1'b1;
        wr_scale  = wr_en;
      end
      `PTA_IDX_ACCESS: begin
        wr_mapped = 1'b1;
        wr_access = wr_en;
      end
      `PTA_IDX_DATA: begin
        wr_mapped = 1'b1;
        wr_data   = wr_en;
      end
      `PTA_IDX_RECOMMEND: begin
        wr_mapped = 1'b1;
      end
      default: begin
        wr_mapped = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // recommended scale per line type
  // -----------------------------------------------------------------
  always_comb begin
    case (line_type)
      pta_pkg::PTA_LT_T1_SH: begin
        rec_scale = `PTA_REC_T1_SH;   // R3
        rec_step  = `PTA_STEP_T1_SH;  // R3
      end
      pta_pkg::PTA_LT_LB_7P5: begin
        rec_scale = `PTA_REC_LB_7P5;  // R4
        rec_step  = `PTA_STEP_LB_7P5; // R4
      end
      pta_pkg::PTA_LT_LB_15: begin
        rec_scale = `PTA_REC_LB_15;   // R5
        rec_step  = `PTA_STEP_LB_15;  // R5
      end
      pta_pkg::PTA_LT_LB_225: begin
        rec_scale = `PTA_REC_LB_22P5;  // R6
        rec_step  = `PTA_STEP_LB_22P5; // R6
      end
      default: begin
        rec_scale = `PTA_REC_E1;  // R7
        rec_step  = `PTA_STEP_E1; // R7
      end
    endcase
  end

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  assign rd_idx = s_axi_araddr[`PTA_ADDR_W+1:2];

  always_comb begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (rd_idx)
      `PTA_IDX_SCALE: begin
        rd_word[`PTA_SCALE_W-1:0] = scale_q; // R2
      end
      `PTA_IDX_ACCESS: begin
        rd_word[7:0] = {trig_q, dir_q, ui_q, samp_q};
      end
      `PTA_IDX_DATA: begin
        rd_word[`PTA_AMP_W-1:0] = data_q; // R13
      end
      `PTA_IDX_RECOMMEND: begin
        rd_word[`PTA_SCALE_W-1:0] = rec_scale;
        rd_word[27:16]            = rec_step;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // write channel
  // -----------------------------------------------------------------
  // one write in flight: readies drop at the handshake and return with bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_idx_q      <= 8'h00;
      w_byte_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PTA_RESP_OKAY;
    end else if (wr_fire) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b1;
      s_axi_bresp   <= wr_mapped ? `PTA_RESP_OKAY : `PTA_RESP_SLVERR;
    end else begin
      if (aw_hs) begin
        aw_got_q      <= 1'b1;
        aw_idx_q      <= s_axi_awaddr[`PTA_ADDR_W+1:2];
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_got_q      <= 1'b1;
        w_byte_q     <= s_axi_wdata[7:0];
        w_lane0_q    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // read channel
  // -----------------------------------------------------------------
  // rdata captured at the address handshake, so later updates cannot tear it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PTA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_mapped ? `PTA_RESP_OKAY : `PTA_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // amplitude scale register
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scale_q <= `PTA_SCALE_RST; // R2
    end else if (wr_scale) begin
      scale_q <= wr_byte[`PTA_SCALE_W-1:0]; // R1
    end
  end

  // -----------------------------------------------------------------
  // access control register
  // -----------------------------------------------------------------
  // fields stay writable while busy; software is expected to wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_q <= 1'b0;
      dir_q  <= 1'b0;
      ui_q   <= 2'h0;
      samp_q <= 4'h0;
    end else begin
      if (wr_access) begin
        dir_q  <= wr_byte[`PTA_DIR_BIT];                  // R9
        ui_q   <= wr_byte[`PTA_UI_HI:`PTA_UI_LO];         // R10
        samp_q <= wr_byte[`PTA_SAMP_HI:`PTA_SAMP_LO];     // R11
      end
      // a new trigger in the clearing cycle wins
      if (wr_access && wr_byte[`PTA_TRIG_BIT]) begin
        trig_q <= 1'b1; // R8
      end else if (state_q == pta_pkg::PTA_FINISH) begin
        trig_q <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // access sequencer
  // -----------------------------------------------------------------
  // three cycles per access: idle sees trigger, exec touches ram, finish clears
  always_comb begin
    case (state_q)
      pta_pkg::PTA_IDLE:   state_d = trig_q ? pta_pkg::PTA_EXEC : pta_pkg::PTA_IDLE; // R8
      pta_pkg::PTA_EXEC:   state_d = pta_pkg::PTA_FINISH;
      pta_pkg::PTA_FINISH: state_d = pta_pkg::PTA_IDLE;
      default:             state_d = pta_pkg::PTA_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= pta_pkg::PTA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign ram_addr = {ui_q, samp_q}; // R10 R11

  // -----------------------------------------------------------------
  // template ram
  // -----------------------------------------------------------------
  // no reset: contents are undefined until software loads them
  always_ff @(posedge aclk) begin
    if (state_q == pta_pkg::PTA_EXEC && !dir_q) begin
      ram_q[ram_addr] <= data_q; // R12
    end
  end

  // -----------------------------------------------------------------
  // sample data register
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= `PTA_DATA_RST;
    end else if (state_q == pta_pkg::PTA_EXEC && dir_q) begin
      data_q <= ram_q[ram_addr]; // R13
    end else if (wr_data) begin
      data_q <= wr_byte[`PTA_AMP_W-1:0]; // R12
    end
  end

  // -----------------------------------------------------------------
  // scaled output toward the waveform shaper
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_scaled_amp <= {`PTA_PROD_W{1'b0}};
      access_busy   <= 1'b0;
    end else begin
      // operands widened first so the product keeps every bit
      tx_scaled_amp <= `PTA_PROD_W'(ram_q[tx_sample_addr]) * `PTA_PROD_W'(scale_q); // R1
      access_busy   <= trig_q;
    end
  end

endmodule : pta_top

`default_nettype wire

/* File: dv/pta_monitor.sv */
// assertion checker for the template access register slave
`timescale 1ns/1ps
`default_nettype none
module pta_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        access_busy
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // bus channels
  // ----------------------------------------
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_aw_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write response");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_r_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // ----------------------------------------
  // sequencer, reset and coverage
  // ----------------------------------------
  a_busy_len: assert property ($rose(access_busy) |-> access_busy [*3] ##1 !access_busy)
    else $error("access length wrong");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !access_busy)
    else $error("not idle after reset");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_busy: cover property ($rose(access_busy));
endmodule : pta_monitor

bind pta_top pta_monitor u_pta_monitor (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .access_busy(access_busy));
`default_nettype wire

/* File: dv/pta_testbench.sv */
// self-checking testbench for the template access block
`timescale 1ns/1ps
`default_nettype none
`include "pta_defs.svh"
module testbench;
  localparam logic [31:0] A_SCL = 32'h1C;
  localparam logic [31:0] A_CTL = 32'h20;
  localparam logic [31:0] A_DAT = 32'h24;
  localparam logic [31:0] A_REC = 32'h3C;
  logic                   aclk, rstn, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, busy;
  logic [31:0]            awa, wd, ara, rd;
  logic [1:0]             bresp, rresp;
  logic [2:0]             lt;
  logic [5:0]             tsa;
  logic [3:0]             strb;
  logic [`PTA_PROD_W-1:0] amp;
  int                     error_cnt, checked;

  pta_top u_pta_top (.aclk(aclk), .aresetn(rstn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(strb), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .line_type(lt), .tx_sample_addr(tsa), .tx_scaled_amp(amp),
    .access_busy(busy));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic bus_wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] e);
    @(posedge aclk);
    awv <= 1'b1;
    awa <= a;
    wv  <= 1'b1;
    wd  <= {24'h0, d};
    br  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) begin
        br <= 1'b0;
        chk("bresp", 32'(bresp), 32'(e));
        break;
      end
    end
  endtask : bus_wr

  task automatic bus_rd(input logic [31:0] a, input logic [1:0] e, output logic [31:0] d);
    @(posedge aclk);
    arv <= 1'b1;
    ara <= a;
    rr  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        rr <= 1'b0;
        d = rd;
        chk("rresp", 32'(rresp), 32'(e));
        break;
      end
    end
  endtask : bus_rd

  // one indirect template access, polled to completion
  task automatic tacc(input logic dir, input logic [5:0] a, input logic [6:0] w, output logic [31:0] d);
    if (!dir) bus_wr(A_DAT, {1'b0, w}, 2'h0);
    bus_wr(A_CTL, {1'b1, dir, a}, 2'h0);
    @(posedge aclk);
    chk("busy", 32'(busy), 32'h1);
    do bus_rd(A_CTL, 2'h0, d); while (d[7] !== 1'b0);
    chk("idle", 32'(busy), 32'h0);
    chk("ctrl_fields", d, {24'h0, 1'b0, dir, a});
    if (dir) bus_rd(A_DAT, 2'h0, d);
  endtask : tacc

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    bus_rd(A_SCL, 2'h0, d);
    chk("scale_rst", d, 32'h21);
    bus_rd(A_CTL, 2'h0, d);
    chk("ctrl_rst", d, 32'h0);
    bus_rd(A_DAT, 2'h0, d);
    chk("data_rst", d, 32'h0);
    bus_rd(32'h10, 2'h2, d);
    chk("unmapped_rd", d, 32'h0);
    bus_wr(32'h10, 8'hFF, 2'h2);
  endtask : t_reset

  task automatic t_scale;
    logic [31:0] d;
    bus_wr(A_SCL, 8'hFF, 2'h0);
    bus_rd(A_SCL, 2'h0, d);
    chk("scale_rsv", d, 32'h3F);
    // lane 0 disabled: the write is answered but must not land
    strb <= 4'hE;
    bus_wr(A_SCL, 8'h00, 2'h0);
    strb <= 4'hF;
    bus_rd(A_SCL, 2'h0, d);
    chk("scale_nostrb", d, 32'h3F);
    bus_wr(A_SCL, 8'h36, 2'h0);
    bus_rd(A_SCL, 2'h0, d);
    chk("scale", d, 32'h36);
  endtask : t_scale

  // line type 5 falls back to the 75/120 ohm setting
  task automatic t_rec;
    logic [5:0]  rs [6] = '{6'h21, 6'h36, 6'h11, 6'h08, 6'h04, 6'h21};
    logic [11:0] st [6] = '{12'h12C, 12'h0C8, 12'h271, 12'h4E2, 12'h9C4, 12'h12C};
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      lt <= 3'(i);
      bus_rd(A_REC, 2'h0, d);
      chk("recommend", d, {4'h0, st[i], 10'h0, rs[i]});
    end
    bus_wr(A_REC, 8'hFF, 2'h0);
    bus_rd(A_REC, 2'h0, d);
    chk("recommend_ro", d, {4'h0, 12'h12C, 10'h0, 6'h21});
  endtask : t_rec

  // corner samples, then playback scaled by two scale values
  task automatic t_ram;
    logic [5:0]  ad [4] = '{6'h00, 6'h3F, 6'h12, 6'h29};
    logic [6:0]  dv [4] = '{7'h7F, 7'h01, 7'h55, 7'h2A};
    logic [31:0] d;
    for (int i = 0; i < 4; i++) tacc(1'b0, ad[i], dv[i], d);
    for (int i = 0; i < 4; i++) begin
      tacc(1'b1, ad[i], 7'h0, d);
      chk("ram_rd", d, {25'h0, dv[i]});
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      tsa <= ad[i];
      repeat (3) @(posedge aclk);
      chk("scaled", 32'(amp), 32'(dv[i]) * 32'h36);
    end
    bus_wr(A_SCL, 8'h04, 2'h0);
    tsa <= ad[0];
    repeat (3) @(posedge aclk);
    chk("scaled_low", 32'(amp), 32'h1FC);
  endtask : t_ram

  initial begin
    {rstn, awv, wv, br, arv, rr} = '0;
    {awa, wd, ara} = '0;
    lt = 3'h0;
    tsa = 6'h0;
    strb = 4'hF;
    error_cnt = 0;
    checked = 0;
    repeat (2) @(posedge aclk);
    rstn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_scale;
    t_rec;
    t_ram;
    tally_and_finish;
  end

  // a few hundred bus cycles expected; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    tally_and_finish;
  end
endmodule : testbench
`default_nettype wire
